// >>> include/pew_pkg.sv
// constants for the page-write memory host controller
package pew_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned COL_W = 6;
  localparam int unsigned PAGE_BYTES = 64;
  // times in their own units
  localparam int unsigned WP_NS = 150;
  localparam int unsigned AS_NS = 10;
  localparam int unsigned NEXT_LOAD_NS = 200;
  localparam int unsigned LOAD_WIN_US = 300;
  localparam int unsigned ACCESS_NS = 200;
  localparam int unsigned POLL_DLY_NS = 200;
  localparam int unsigned WRITE_MAX_MS = 10;
  localparam int unsigned NS_PER_CYC = 1000000000 / CLK_HZ;
  // least times round up
  localparam int unsigned WP_CYC = (WP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned AS_CYC0 = (AS_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned AS_CYC = AS_CYC0 < 1 ? 1 : AS_CYC0;
  localparam int unsigned GAP_CYC =
    (NEXT_LOAD_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned ACC_CYC =
    (ACCESS_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned POLL_CYC =
    (POLL_DLY_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned LOAD_WIN_CYC = LOAD_WIN_US * (CLK_HZ / 1000000);
  localparam int unsigned WRITE_MAX_CYC = WRITE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  typedef enum logic [6:0] {
    PEW_IDLE  = 7'h01,
    PEW_SETUP = 7'h02,
    PEW_WLOW  = 7'h04,
    PEW_GAP   = 7'h08,
    PEW_RD    = 7'h10,
    PEW_WAIT  = 7'h20,
    PEW_POLL  = 7'h40
  } pew_state_t;
endpackage

// >>> verilog/pew_host.sv
// host controller driving a 32k x 8 page-write memory over its pins
//
// Behaviour
// - host keeps write enable high during every read.
// - write starts with chip select and write enable low, oe high.
// - host holds write enable low at least the minimum pulse width.
// - next byte no sooner than 0.2 us; device waits 300 us idle.
// - host may stretch a load by holding write enable low; here each pulse lasts WP_CYC cycles.
// - only logic levels used; chip erase mode not driven.
`timescale 1ns/100ps
`default_nettype none
module pew_host (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_last_in,
  input wire logic [14:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic wr_done_out,
  output logic wr_timeout_out,
  output logic busy_out,
  output logic [14:0] mem_addr_out,
  output logic mem_ce_n_out,
  output logic mem_oe_n_out,
  output logic mem_we_n_out,
  input wire logic [7:0] mem_dq_in,
  output logic [7:0] mem_dq_out,
  output logic mem_dq_oe_n_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pew_pkg::pew_state_t st_q, st_d;
  logic [pew_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [pew_pkg::CNT_W-1:0] tmo_q, tmo_d;
  logic [14:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic [7:0] last_q, last_d;
  logic [8:0] row_q, row_d;
  logic in_page_q, in_page_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_n_q, dq_oe_n_d;
  logic rdv_q, rdv_d, done_q, done_d, tmof_q, tmof_d, lastf_q, lastf_d;
  logic [7:0] rdat_q, rdat_d;

  localparam logic [pew_pkg::CNT_W-1:0] C_AS = pew_pkg::AS_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_WP = pew_pkg::WP_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_GAP = pew_pkg::GAP_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_ACC = pew_pkg::ACC_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_POLL = pew_pkg::POLL_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_WIN = pew_pkg::LOAD_WIN_CYC[19:0];
  localparam logic [pew_pkg::CNT_W-1:0] C_WMAX =
    pew_pkg::WRITE_MAX_CYC[19:0];

  function automatic logic same_row(input logic [14:0] a,
                                    input logic [8:0] r);
    same_row = (a[14:6] == r);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h00001;
    tmo_d = tmo_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    last_d = last_q;
    row_d = row_q;
    in_page_d = in_page_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dq_oe_n_d = dq_oe_n_q;
    rdv_d = 1'b0;
    done_d = 1'b0;
    tmof_d = 1'b0;
    lastf_d = lastf_q;
    rdat_d = rdat_q;
    case (st_q)
      pew_pkg::PEW_IDLE: begin
        // page stays open only while next byte is on the same row
        if (req_valid_in) begin
          cnt_d = 20'h00000;
          if (in_page_q && (!req_write_in ||
                            !same_row(req_addr_in, row_q))) begin
            // address kept, so polling still reads the last byte back
            st_d = pew_pkg::PEW_WAIT;
            tmo_d = 20'h00000;
          end else if (req_write_in) begin
            addr_d = req_addr_in;
            wdat_d = req_data_in;
            lastf_d = req_last_in;
            if (!in_page_q) row_d = req_addr_in[14:6];
            ce_n_d = 1'b0;
            oe_n_d = 1'b1;
            we_n_d = 1'b1;
            st_d = pew_pkg::PEW_SETUP;
          end else begin
            addr_d = req_addr_in;
            ce_n_d = 1'b0;
            oe_n_d = 1'b0;
            we_n_d = 1'b1;
            dq_oe_n_d = 1'b1;
            st_d = pew_pkg::PEW_RD;
          end
        end
      end
      pew_pkg::PEW_SETUP: begin
        if (cnt_q + 20'h00001 >= C_AS) begin
          we_n_d = 1'b0;
          dq_oe_n_d = 1'b0;
          cnt_d = 20'h00000;
          st_d = pew_pkg::PEW_WLOW;
        end
      end
      pew_pkg::PEW_WLOW: begin
        // holding low keeps the device load timer reset
        if (cnt_q + 20'h00001 >= C_WP) begin
          we_n_d = 1'b1;
          last_d = wdat_q;
          in_page_d = 1'b1;
          cnt_d = 20'h00000;
          st_d = pew_pkg::PEW_GAP;
        end
      end
      pew_pkg::PEW_GAP: begin
        if (cnt_q + 20'h00001 >= C_GAP) begin
          ce_n_d = 1'b1;
          dq_oe_n_d = 1'b1;
          if (lastf_q) begin
            tmo_d = 20'h00000;
            st_d = pew_pkg::PEW_WAIT;
          end else begin
            tmo_d = 20'h00000;
            st_d = pew_pkg::PEW_IDLE;
          end
        end
      end
      pew_pkg::PEW_RD: begin
        // latches are transparent, so sample only after full access
        if (cnt_q + 20'h00001 >= C_ACC) begin
          rdat_d = mem_dq_in;
          rdv_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d = pew_pkg::PEW_IDLE;
        end
      end
      pew_pkg::PEW_WAIT: begin
        // device closes the page after its idle window
        tmo_d = tmo_q + 20'h00001;
        if (tmo_q + 20'h00001 >= C_WIN) begin
          cnt_d = 20'h00000;
          st_d = pew_pkg::PEW_POLL;
          ce_n_d = 1'b0;
          oe_n_d = 1'b0;
        end
      end
      pew_pkg::PEW_POLL: begin
        tmo_d = tmo_q + 20'h00001;
        if (cnt_q + 20'h00001 >= C_POLL) begin
          cnt_d = 20'h00000;
          if (mem_dq_in == last_q) begin
            done_d = 1'b1;
            in_page_d = 1'b0;
            ce_n_d = 1'b1;
            oe_n_d = 1'b1;
            st_d = pew_pkg::PEW_IDLE;
          end else if (tmo_q >= C_WIN + C_WMAX) begin
            tmof_d = 1'b1;
            in_page_d = 1'b0;
            ce_n_d = 1'b1;
            oe_n_d = 1'b1;
            st_d = pew_pkg::PEW_IDLE;
          end
        end
      end
      default: st_d = pew_pkg::PEW_IDLE;
    endcase
    // idle open page times out by itself at the device
    if (st_q == pew_pkg::PEW_IDLE && in_page_q && !req_valid_in) begin
      tmo_d = tmo_q + 20'h00001;
      if (tmo_q + 20'h00001 >= C_WIN) begin
        cnt_d = 20'h00000;
        st_d = pew_pkg::PEW_POLL;
        ce_n_d = 1'b0;
        oe_n_d = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= pew_pkg::PEW_IDLE;
      cnt_q <= 20'h00000;
      tmo_q <= 20'h00000;
      addr_q <= pew_pkg::ADDR_RST;
      wdat_q <= pew_pkg::DATA_RST;
      last_q <= pew_pkg::DATA_RST;
      row_q <= 9'h000;
      in_page_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_n_q <= 1'b1;
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      tmof_q <= 1'b0;
      lastf_q <= 1'b0;
      rdat_q <= pew_pkg::DATA_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      last_q <= last_d;
      row_q <= row_d;
      in_page_q <= in_page_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dq_oe_n_q <= dq_oe_n_d;
      rdv_q <= rdv_d;
      done_q <= done_d;
      tmof_q <= tmof_d;
      lastf_q <= lastf_d;
      rdat_q <= rdat_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign req_ready_out = (st_q == pew_pkg::PEW_IDLE);
  assign rd_valid_out = rdv_q;
  assign rd_data_out = rdat_q;
  assign wr_done_out = done_q;
  assign wr_timeout_out = tmof_q;
  assign busy_out = (st_q != pew_pkg::PEW_IDLE) || in_page_q;
  assign mem_addr_out = addr_q;
  assign mem_ce_n_out = ce_n_q;
  assign mem_oe_n_out = oe_n_q;
  assign mem_we_n_out = we_n_q;
  assign mem_dq_out = wdat_q;
  assign mem_dq_oe_n_out = dq_oe_n_q;
endmodule
`default_nettype wire

// >>> tb/pew_host_properties.sv
// pin-side assertions for the page-write host controller
`timescale 1ns/100ps
`default_nettype none
module pew_host_properties (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_ready_out,
  input wire logic busy_out,
  input wire logic [14:0] req_addr_in,
  input wire logic rd_valid_out,
  input wire logic [14:0] mem_addr_out,
  input wire logic mem_ce_n_out,
  input wire logic mem_oe_n_out,
  input wire logic mem_we_n_out,
  input wire logic mem_dq_oe_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  logic rd_take;
  // a read during an open page is refused, so it is no take
  assign rd_take = req_valid_in && req_ready_out && !req_write_in &&
    !busy_out;
  rd_answer_a: assert property (rd_take |-> ##3 rd_valid_out)
    else $error("read answer late");
  rd_addr_a: assert property (rd_take |=>
    mem_addr_out == $past(req_addr_in) && !mem_oe_n_out)
    else $error("read address wrong");
  rd_release_a: assert property (rd_valid_out |-> mem_oe_n_out)
    else $error("output enable held");
  rd_we_a: assert property (!mem_oe_n_out |-> mem_we_n_out)
    else $error("write enable low in read");
  wr_mix_a: assert property (!mem_we_n_out |->
    !mem_ce_n_out && mem_oe_n_out)
    else $error("write mix wrong");
  we_width_a: assert property ($fell(mem_we_n_out) |->
    !mem_we_n_out [*2])
    else $error("write pulse short");
  load_gap_a: assert property ($rose(mem_we_n_out) |->
    mem_we_n_out [*2])
    else $error("byte gap short");
  dq_clash_a: assert property (!mem_dq_oe_n_out |-> mem_oe_n_out)
    else $error("bus driven in read");
endmodule
bind pew_host pew_host_properties i_pew_host_properties (
  .clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
  .req_write_in(req_write_in), .req_ready_out(req_ready_out),
  .busy_out(busy_out),
  .req_addr_in(req_addr_in), .rd_valid_out(rd_valid_out),
  .mem_addr_out(mem_addr_out), .mem_ce_n_out(mem_ce_n_out),
  .mem_oe_n_out(mem_oe_n_out), .mem_we_n_out(mem_we_n_out),
  .mem_dq_oe_n_out(mem_dq_oe_n_out));
`default_nettype wire

// >>> tb/pew_mem_model.sv
// behavioural page-write memory seen from its pins
`timescale 1ns/100ps
`default_nettype none
module pew_mem_model #(
  parameter int WR_CYC = 150
) (
  input wire logic clock_in,
  input wire logic [14:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] dq_in,
  input wire logic dq_oe_n_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_q = 8'h00;
  logic [7:0] din;
  logic [14:0] wa_q = 15'h0000;
  logic [8:0] row_q = 9'h000;
  logic open_q = 1'b0;
  logic ctl_q = 1'b1;
  logic ctl_n;
  int tmr_q = 0;
  int bsy_q = 0;
  assign ctl_n = we_n_in | ce_n_in | ~oe_n_in;
  assign din = dq_oe_n_in ? ~dq_in : dq_in;
  // an undriven bus toggles so a stale byte cannot pass
  always_comb begin
    dq_out = 8'ha5 ^ {8{clock_in}};
    if (!ce_n_in && !oe_n_in && we_n_in) begin
      dq_out = (open_q || bsy_q != 0) ? ~last_q : mem[addr_in];
    end
  end
  // pins sampled per clock, so a glitch that spans no rising clock edge never registers
  always @(posedge clock_in) begin
    ctl_q <= ctl_n;
    if (bsy_q != 0) begin
      bsy_q <= bsy_q - 1;
    end else if (!ctl_n) begin
      tmr_q <= 0;
      if (ctl_q) begin
        wa_q <= {open_q ? row_q : addr_in[14:6], addr_in[5:0]};
        row_q <= open_q ? row_q : addr_in[14:6];
        open_q <= 1'b1;
      end
    end else if (!ctl_q) begin
      mem[wa_q] <= din;
      last_q <= din;
      tmr_q <= 1;
    end else if (open_q && tmr_q >= pew_pkg::LOAD_WIN_CYC) begin
      open_q <= 1'b0;
      bsy_q <= WR_CYC;
    end else if (open_q) begin
      tmr_q <= tmr_q + 1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the page-write host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic req_last_in = 1'b0;
  logic [14:0] req_addr_in = 15'h0000;
  logic [7:0] req_data_in = 8'h00;
  logic req_ready_out, rd_valid_out, wr_done_out, wr_timeout_out, busy_out;
  logic ce_n, oe_n, we_n, dq_oe_n;
  logic [7:0] rd_data_out, mem_dq_in, mem_dq_out;
  logic [14:0] mem_addr_out;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam int LIM = 20000;
  always #50 clock_in = ~clock_in;
  pew_host i_pew_host (.clock_in(clock_in), .rstn_in(rstn_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_last_in(req_last_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .wr_done_out(wr_done_out), .wr_timeout_out(wr_timeout_out),
    .busy_out(busy_out), .mem_addr_out(mem_addr_out),
    .mem_ce_n_out(ce_n), .mem_oe_n_out(oe_n), .mem_we_n_out(we_n),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n_out(dq_oe_n));
  pew_mem_model i_pew_mem_model (.clock_in(clock_in),
    .addr_in(mem_addr_out), .ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .dq_in(mem_dq_out), .dq_oe_n_in(dq_oe_n),
    .dq_out(mem_dq_in));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a spent bound ends the run at once
  task automatic hang(input logic spent);
    if (spent) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic req(input logic w, input logic l, input logic [14:0] a,
                     input logic [7:0] d);
    int i;
    i = 0;
    while (req_ready_out !== 1'b1 && i < LIM) begin
      @(negedge clock_in);
      i++;
    end
    hang(req_ready_out !== 1'b1);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_last_in = l;
    req_addr_in = a;
    req_data_in = d;
    @(negedge clock_in);
    req_valid_in = 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    int i;
    req(1'b0, 1'b0, a, 8'h00);
    i = 0;
    while (rd_valid_out !== 1'b1 && i < 10) begin
      @(negedge clock_in);
      i++;
    end
    hang(rd_valid_out !== 1'b1);
    cmp(rd_data_out, e);
  endtask
  task automatic wdone();
    int i;
    i = 0;
    while (wr_done_out !== 1'b1 && i < LIM) begin
      @(negedge clock_in);
      cmp({7'h00, wr_timeout_out}, 8'h00);
      i++;
    end
    hang(wr_done_out !== 1'b1);
  endtask
  task automatic t_byte();
    logic [7:0] v [2];
    v = '{8'h5a, 8'ha5};
    for (int k = 0; k < 2; k++) begin
      req(1'b1, 1'b1, 15'h0123, v[k]);
      wdone();
      rd(15'h0123, v[k]);
    end
    $display("test byte done");
  endtask
  // long gaps keep the page open only if each byte restarts the window
  task automatic t_page();
    for (int k = 0; k < 4; k++) begin
      req(1'b1, k == 3, {9'h1a5, 6'(63 - k * 21)}, 8'(8'h10 + k));
      if (k < 3) begin
        repeat (2000) @(negedge clock_in);
        cmp({7'h00, busy_out}, 8'h01);
      end
    end
    wdone();
    for (int k = 0; k < 4; k++) begin
      rd({9'h1a5, 6'(k * 21)}, 8'(8'h13 - k));
    end
    $display("test page done");
  endtask
  // a byte for a new row must wait until the open page is written
  task automatic t_row();
    req(1'b1, 1'b0, {9'h0c3, 6'h05}, 8'h3c);
    req(1'b1, 1'b1, {9'h0c4, 6'h09}, 8'hc3);
    cmp({7'h00, req_ready_out}, 8'h00);
    wdone();
    cmp({7'h00, busy_out}, 8'h00);
    rd({9'h0c3, 6'h05}, 8'h3c);
    req(1'b1, 1'b1, {9'h0c4, 6'h09}, 8'hc3);
    wdone();
    rd({9'h0c4, 6'h09}, 8'hc3);
    $display("test row done");
  endtask
  initial begin
    repeat (10) @(negedge clock_in);
    cmp({4'h0, ce_n, oe_n, we_n, dq_oe_n}, 8'h0f);
    rstn_in = 1'b1;
    $display("test reset done");
    t_byte();
    t_page();
    t_row();
    print_verdict();
  end
endmodule
`default_nettype wire
